// >>> rtl/host_bridge_config_header.sv
// Host bridge configuration header registers with aperture base decode
//
// What this block does
// - Offset 08h returns read-only 8-bit revision number; writes ignored.
// - Offset 0Ah returns read-only sub-class code 00h, a host bridge.
// - Offset 0Bh returns read-only base class code 06h, a bridge.
// - Latency timer at 0Dh unimplemented, reads 00h.
// - Header type at 0Eh has no storage, always reads 0.
// - Aperture base bits 31:28 are writable and give address bits 31:28.
// - Aperture bits 27:22 writable unless size mask forces them to zero.
// - Aperture bits 21:4 always read zero; minimum aperture is 4 MB.
// - Aperture bit 3 always reads 1, prefetchable.
// - Aperture bits 2:1 read 00, anywhere in 32-bit space.
// - Processor memory accesses inside the aperture are flagged for translation.
// - Aperture reads return all bytes; writes may merge.
// - Aperture accesses are blocked until misc config bit 1 is set.
// - Aperture enable resets to 0; software sets it after configuration.
`timescale 1ns/1ns
`default_nettype none
module host_bridge_config_header #(
   parameter logic [7:0] REVISION_VALUE = host_bridge_pkg::REVISION_DEFAULT // Arbitrary value
) (
   input  wire logic        clk_sys_in,
   input  wire logic        rst_b_in,
   input  wire logic        cfg_write_in,
   input  wire logic        cfg_read_in,
   input  wire logic [7:0]  cfg_offset_in,
   input  wire logic [3:0]  cfg_byte_en_in,
   input  wire logic [31:0] cfg_wdata_in,
   output logic      [31:0] cfg_rdata_out,
   input  wire logic [5:0]  aperture_size_mask_in,
   input  wire logic        mem_req_in,
   input  wire logic [31:0] mem_addr_in,
   input  wire logic [3:0]  mem_byte_en_in,
   output logic             aperture_hit_out,
   output logic             aperture_translate_out,
   output logic             aperture_blocked_out,
   output logic      [3:0]  aperture_byte_en_out,
   output logic             aperture_access_enable_out
);
   logic [3:0] upper_base_bits;
   logic [5:0] maskable_base_bits;
   logic       aperture_access_enable;
   logic [7:0] graphics_misc_config;

   // Dword-aligned decode; the offset selects the dword and byte lanes pick within it
   function automatic logic hits(input logic [7:0] off, input logic [7:0] reg_off);
      hits = (off[7:2] == reg_off[7:2]);
   endfunction : hits

   wire logic        wr_aperture  = cfg_write_in && hits(cfg_offset_in,
                                    host_bridge_pkg::OFF_APERTURE);
   wire logic        wr_misc      = cfg_write_in && hits(cfg_offset_in,
                                    host_bridge_pkg::OFF_GRAPHICS_MISC);
   wire logic [1:0]  misc_lane    = host_bridge_pkg::OFF_GRAPHICS_MISC[1:0];
   wire logic        misc_lane_en = cfg_byte_en_in[misc_lane];
   wire logic [7:0]  misc_wbyte   = cfg_wdata_in[8*misc_lane +: 8];
   // Masked bits can never hold a one, so a later size change cannot expose stale bits
   wire logic [5:0]  mid_visible  = maskable_base_bits & ~aperture_size_mask_in;
   wire logic [31:0] aperture_word = {upper_base_bits, mid_visible,
                                      host_bridge_pkg::LOW_ZERO,
                                      host_bridge_pkg::PREFETCH_VALUE,
                                      host_bridge_pkg::ADDR_TYPE_VALUE,
                                      host_bridge_pkg::MEM_SPACE_VALUE};
   wire logic [31:0] id_dword     = {host_bridge_pkg::BASE_CLASS_BRIDGE,
                                     host_bridge_pkg::SUB_CLASS_HOST,
                                     8'h00,
                                     REVISION_VALUE};
   wire logic [31:0] hdr_dword    = {8'h00,
                                     host_bridge_pkg::HEADER_VALUE,
                                     host_bridge_pkg::LATENCY_VALUE,
                                     8'h00};
   wire logic [31:0] misc_dword   = {16'h0000, graphics_misc_config, 8'h00};
   wire logic        sel_id_dword   = hits(cfg_offset_in, host_bridge_pkg::OFF_REVISION);
   wire logic        sel_hdr_dword  = hits(cfg_offset_in, host_bridge_pkg::OFF_LATENCY);
   wire logic        sel_aperture   = hits(cfg_offset_in, host_bridge_pkg::OFF_APERTURE);
   wire logic        sel_misc_dword = hits(cfg_offset_in, host_bridge_pkg::OFF_GRAPHICS_MISC);
   wire logic        sel_unmapped   = !(sel_id_dword || sel_hdr_dword || sel_aperture
                                        || sel_misc_dword);
   wire logic [31:0] next_rdata     =
      sel_id_dword   ? id_dword :
      sel_hdr_dword  ? hdr_dword :
      sel_aperture   ? aperture_word :
      sel_misc_dword ? misc_dword : 32'h00000000;

   assign graphics_misc_config = {6'h00, aperture_access_enable, 1'b0};

   // Lane-qualified update of the programmable base bits
   wire logic       wr_upper_lane = wr_aperture && cfg_byte_en_in[3];
   wire logic       wr_mid_lane   = wr_aperture && cfg_byte_en_in[2];
   wire logic [3:0] next_upper_bits = wr_upper_lane ? cfg_wdata_in[31:28] : upper_base_bits;
   wire logic [3:0] mid_hi_new = wr_upper_lane ? cfg_wdata_in[27:24] : maskable_base_bits[5:2];
   wire logic [1:0] mid_lo_new = wr_mid_lane ? cfg_wdata_in[23:22] : maskable_base_bits[1:0];
   // Cleared every cycle while masked, so narrowing the size later exposes no stale ones
   wire logic [5:0] next_maskable_bits = {mid_hi_new, mid_lo_new} & ~aperture_size_mask_in;

   // Only the programmable base bits and the aperture enable have storage; every other field is a constant
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         upper_base_bits    <= host_bridge_pkg::UPPER_RESET;
         maskable_base_bits <= host_bridge_pkg::MASKABLE_RESET;
      end else begin
         upper_base_bits    <= next_upper_bits;
         maskable_base_bits <= next_maskable_bits;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         aperture_access_enable <= 1'b0;
      end else if (wr_misc && misc_lane_en) begin
         aperture_access_enable <= misc_wbyte[host_bridge_pkg::APERTURE_ACCESS_ENABLE_BIT];
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cfg_rdata_out <= 32'h00000000;
      end else if (cfg_read_in) begin
         cfg_rdata_out <= next_rdata;
      end
   end

   // Aperture window compare; base granularity follows the visible base bits
   wire logic [9:0] base_hi   = {upper_base_bits, mid_visible};
   wire logic [9:0] addr_hi   = {mem_addr_in[31:28], mem_addr_in[27:22]};
   wire logic [9:0] cmp_mask  = {4'hf, ~aperture_size_mask_in};
   wire logic       in_window = ((addr_hi & cmp_mask) == (base_hi & cmp_mask));

   assign aperture_hit_out           = mem_req_in && in_window;
   assign aperture_translate_out     = aperture_hit_out && aperture_access_enable;
   assign aperture_blocked_out       = aperture_hit_out && !aperture_access_enable;
   // Prefetchable range, once enabled: full dword returned whatever lanes were asked for
   assign aperture_byte_en_out       = aperture_translate_out ? 4'hf : mem_byte_en_in;
   assign aperture_access_enable_out = aperture_access_enable;

   a_aperture_fixed_bits: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      cfg_read_in && hits(cfg_offset_in, host_bridge_pkg::OFF_APERTURE)
      |=> cfg_rdata_out[21:0] == 22'h000008)
      else $error("Aperture fixed bits wrong");
   a_mask_reads_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      cfg_read_in && sel_aperture
      |=> (cfg_rdata_out[27:22] & $past(aperture_size_mask_in)) == 6'h00)
      else $error("Masked aperture bit visible");
   a_upper_bits_write: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      wr_aperture && cfg_byte_en_in[3] |=> upper_base_bits == $past(cfg_wdata_in[31:28]))
      else $error("Upper base bits not written");
   a_class_codes: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      cfg_read_in && hits(cfg_offset_in, host_bridge_pkg::OFF_REVISION)
      |=> cfg_rdata_out[31:16] == 16'h0600)
      else $error("Class codes wrong");
   a_revision_value: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      cfg_read_in && hits(cfg_offset_in, host_bridge_pkg::OFF_REVISION)
      |=> cfg_rdata_out[7:0] == REVISION_VALUE)
      else $error("Revision value wrong");
   a_header_latency: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      cfg_read_in && hits(cfg_offset_in, host_bridge_pkg::OFF_LATENCY)
      |=> cfg_rdata_out == 32'h00000000)
      else $error("Header or latency not zero");
   a_blocked_no_xlate: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      aperture_hit_out && !aperture_access_enable_out
      |-> aperture_blocked_out && !aperture_translate_out)
      else $error("Aperture access not blocked");
   a_full_lanes: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      aperture_translate_out |-> aperture_byte_en_out == 4'hf)
      else $error("Aperture lanes not full");
   a_enable_write: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      wr_misc && misc_lane_en |=> aperture_access_enable_out == $past(misc_wbyte[1]))
      else $error("Aperture enable not updated");
   a_ro_write_ignored: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      cfg_write_in && !wr_aperture |=> $stable(upper_base_bits))
      else $error("Read-only write changed state");
   a_translate_hit: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      aperture_translate_out |-> mem_req_in && mem_addr_in[31:28] == upper_base_bits)
      else $error("Translation outside window");

   // Identification and header words, unmapped reads and read data hold
   a_base_class_code: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      cfg_read_in && sel_id_dword
      |=> cfg_rdata_out[31:24] == host_bridge_pkg::BASE_CLASS_BRIDGE)
      else $error("Base class code wrong");
   a_sub_class_code: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      cfg_read_in && sel_id_dword
      |=> cfg_rdata_out[23:16] == host_bridge_pkg::SUB_CLASS_HOST)
      else $error("Sub-class code wrong");
   a_header_type_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      cfg_read_in && sel_hdr_dword
      |=> cfg_rdata_out[23:16] == host_bridge_pkg::HEADER_VALUE)
      else $error("Header type not zero");
   a_latency_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      cfg_read_in && sel_hdr_dword
      |=> cfg_rdata_out[15:8] == host_bridge_pkg::LATENCY_VALUE)
      else $error("Latency timer not zero");
   a_unmapped_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      cfg_read_in && sel_unmapped
      |=> cfg_rdata_out == 32'h00000000)
      else $error("Unmapped read not zero");
   a_rdata_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      !cfg_read_in |=> $stable(cfg_rdata_out))
      else $error("Read data changed without a read");

   // Fixed and programmable fields of the aperture base word
   a_prefetch_bit: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      cfg_read_in && sel_aperture
      |=> cfg_rdata_out[3] == host_bridge_pkg::PREFETCH_VALUE)
      else $error("Prefetchable flag wrong");
   a_addr_type_bits: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      cfg_read_in && sel_aperture
      |=> cfg_rdata_out[2:1] == host_bridge_pkg::ADDR_TYPE_VALUE)
      else $error("Address type bits wrong");
   a_mem_space_bit: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      cfg_read_in && sel_aperture
      |=> cfg_rdata_out[0] == host_bridge_pkg::MEM_SPACE_VALUE)
      else $error("Memory space flag wrong");
   a_low_bits_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      cfg_read_in && sel_aperture
      |=> cfg_rdata_out[21:4] == host_bridge_pkg::LOW_ZERO)
      else $error("Low base bits not zero");
   a_ap_read_upper: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      cfg_read_in && sel_aperture
      |=> cfg_rdata_out[31:28] == $past(upper_base_bits))
      else $error("Upper base bits read wrong");
   a_ap_read_mid: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      cfg_read_in && sel_aperture
      |=> cfg_rdata_out[27:22] == $past(mid_visible))
      else $error("Middle base bits read wrong");

   // Programmable base storage
   a_masked_not_stored: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      1'b1 |=> (maskable_base_bits & $past(aperture_size_mask_in)) == 6'h00)
      else $error("Masked base bit stored");
   a_mid_lo_write: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      wr_aperture && cfg_byte_en_in[2]
      |=> maskable_base_bits[1:0] == ($past(cfg_wdata_in[23:22]) & ~$past(aperture_size_mask_in[1:0])))
      else $error("Low middle bits not written");
   a_mid_hi_write: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      wr_aperture && cfg_byte_en_in[3]
      |=> maskable_base_bits[5:2] == ($past(cfg_wdata_in[27:24]) & ~$past(aperture_size_mask_in[5:2])))
      else $error("High middle bits not written");
   a_mid_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      !wr_aperture
      |=> maskable_base_bits == ($past(maskable_base_bits) & ~$past(aperture_size_mask_in)))
      else $error("Middle bits changed without a write");
   a_upper_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      !wr_aperture |=> $stable(upper_base_bits))
      else $error("Upper bits changed without a write");
   a_upper_lane_only: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      wr_aperture && !cfg_byte_en_in[3] |=> $stable(upper_base_bits))
      else $error("Upper bits written without their lane");

   // Aperture enable register
   a_enable_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      !(wr_misc && misc_lane_en) |=> $stable(aperture_access_enable_out))
      else $error("Aperture enable changed without a write");
   a_enable_reset: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      $rose(rst_b_in) |-> !aperture_access_enable_out)
      else $error("Aperture enable not clear after reset");
   a_misc_read: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      cfg_read_in && sel_misc_dword
      |=> cfg_rdata_out[15:8] == {6'h00, $past(aperture_access_enable), 1'b0})
      else $error("Misc config read wrong");
   a_misc_reserved: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      cfg_read_in && sel_misc_dword
      |=> cfg_rdata_out[31:16] == 16'h0000 && cfg_rdata_out[7:0] == 8'h00)
      else $error("Misc reserved bytes not zero");

   // Processor side decode, plus read data hold across config writes
   a_hit_needs_req: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      !mem_req_in |-> !aperture_hit_out)
      else $error("Hit without a request");
   a_hit_in_window: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      mem_req_in && in_window |-> aperture_hit_out)
      else $error("Window access not flagged");
   a_window_miss: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      mem_req_in && !in_window |-> !aperture_hit_out)
      else $error("Hit outside window");
   a_enable_translates: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      aperture_hit_out && aperture_access_enable_out
      |-> aperture_translate_out && !aperture_blocked_out)
      else $error("Enabled hit not translated");
   a_blocked_needs_hit: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      aperture_blocked_out |-> aperture_hit_out)
      else $error("Blocked without a hit");
   a_xlate_needs_en: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      aperture_translate_out |-> aperture_access_enable_out)
      else $error("Translation while disabled");
   a_block_xor_xlate: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      !(aperture_translate_out && aperture_blocked_out))
      else $error("Blocked and translated together");
   a_lanes_pass: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      !aperture_translate_out |-> aperture_byte_en_out == mem_byte_en_in)
      else $error("Byte lanes altered outside aperture");
   a_blocked_lanes: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      aperture_blocked_out |-> aperture_byte_en_out == mem_byte_en_in)
      else $error("Blocked access lanes altered");
   a_write_rdata_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      cfg_write_in && !cfg_read_in |=> $stable(cfg_rdata_out))
      else $error("Write changed read data");

   c_enable_set: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      wr_misc && misc_lane_en && misc_wbyte[1]);
   c_translate: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      aperture_translate_out);
   c_blocked: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      aperture_blocked_out);
   c_masked_write: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      wr_aperture && (aperture_size_mask_in != 6'h00));
   c_unmapped_read: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      cfg_read_in && sel_unmapped);
endmodule : host_bridge_config_header
`default_nettype wire

// >>> rtl/host_bridge_pkg.sv
// Offsets, field positions and fixed values for the host bridge configuration header
package host_bridge_pkg;
   localparam logic [7:0] OFF_REVISION     = 8'h08;
   localparam logic [7:0] OFF_SUB_CLASS    = 8'h0a;
   localparam logic [7:0] OFF_BASE_CLASS   = 8'h0b;
   localparam logic [7:0] OFF_LATENCY      = 8'h0d;
   localparam logic [7:0] OFF_HEADER_TYPE  = 8'h0e;
   localparam logic [7:0] OFF_APERTURE     = 8'h10;
   localparam logic [7:0] OFF_GRAPHICS_MISC = 8'h51;
   localparam logic [7:0] SUB_CLASS_HOST   = 8'h00;
   localparam logic [7:0] BASE_CLASS_BRIDGE = 8'h06;
   localparam logic [7:0] LATENCY_VALUE    = 8'h00;
   localparam logic [7:0] HEADER_VALUE     = 8'h00;
   localparam logic [3:0] UPPER_RESET      = 4'h0;
   localparam logic [5:0] MASKABLE_RESET   = 6'h00;
   localparam logic [17:0] LOW_ZERO        = 18'h00000;
   localparam logic       PREFETCH_VALUE   = 1'b1;
   localparam logic [1:0] ADDR_TYPE_VALUE  = 2'h0;
   localparam logic       MEM_SPACE_VALUE  = 1'b0;
   localparam int         APERTURE_ACCESS_ENABLE_BIT         = 1;
   localparam logic [7:0] REVISION_DEFAULT = 8'h5a;
endpackage : host_bridge_pkg

// >>> test/host_bridge_config_header_test.sv
// Self-checking bench for the host bridge configuration header
`timescale 1ns/1ns
`default_nettype none
module host_bridge_config_header_test;
   localparam logic [7:0] REV = 8'h3c; // Arbitrary revision value
   logic        clk_sys_in     = 1'b0;
   logic        rst_b_in       = 1'b0;
   logic        cfg_write_in   = 1'b0;
   logic        cfg_read_in    = 1'b0;
   logic [7:0]  cfg_offset_in  = 8'h00;
   logic [3:0]  cfg_byte_en_in = 4'h0;
   logic [31:0] cfg_wdata_in   = 32'h0;
   logic [5:0]  mask           = 6'h00;
   logic        mem_req_in     = 1'b0;
   logic [31:0] mem_addr_in    = 32'h0;
   logic [3:0]  mem_byte_en_in = 4'h0;
   logic [31:0] rdata;
   logic        hit, xlat, blk, en_out;
   logic [3:0]  be_out;
   logic [9:0]  base = 10'h000;
   logic        en   = 1'b0;
   logic [31:0] r, a;
   int          errors = 0;
   int          comparisons = 0;

   host_bridge_config_header #(.REVISION_VALUE(REV)) dut_u (
      .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .cfg_write_in(cfg_write_in),
      .cfg_read_in(cfg_read_in), .cfg_offset_in(cfg_offset_in),
      .cfg_byte_en_in(cfg_byte_en_in), .cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(rdata),
      .aperture_size_mask_in(mask), .mem_req_in(mem_req_in), .mem_addr_in(mem_addr_in),
      .mem_byte_en_in(mem_byte_en_in), .aperture_hit_out(hit), .aperture_translate_out(xlat),
      .aperture_blocked_out(blk), .aperture_byte_en_out(be_out),
      .aperture_access_enable_out(en_out));

   always #50 clk_sys_in = ~clk_sys_in;

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Strobe is one cycle wide; read data is looked at just after the taking edge
   task automatic cfg_op(input logic wr, input logic [7:0] off, input logic [3:0] be,
                         input logic [31:0] d);
      @(posedge clk_sys_in);
      #1;
      cfg_write_in = wr;
      cfg_read_in = ~wr;
      cfg_offset_in = off;
      cfg_byte_en_in = be;
      cfg_wdata_in = d;
      @(posedge clk_sys_in);
      #1;
      cfg_write_in = 1'b0;
      cfg_read_in = 1'b0;
   endtask : cfg_op

   function automatic logic [9:0] next_base(input logic [9:0] old, input logic [3:0] be,
                                            input logic [31:0] d, input logic [5:0] m);
      next_base = {be[3] ? d[31:24] : old[9:2], be[2] ? d[23:22] : old[1:0]} & ~{4'h0, m};
   endfunction : next_base

   task automatic mem_chk(input logic [31:0] addr, input logic req, input logic exp_hit);
      @(posedge clk_sys_in);
      #1;
      mem_req_in = req;
      mem_addr_in = addr;
      mem_byte_en_in = 4'($urandom);
      #10;
      chk("hit", {31'h0, exp_hit}, {31'h0, hit});
      chk("translate", {31'h0, exp_hit & en}, {31'h0, xlat});
      chk("blocked", {31'h0, exp_hit & ~en}, {31'h0, blk});
      chk("byte lanes", {28'h0, (exp_hit & en) ? 4'hf : mem_byte_en_in}, {28'h0, be_out});
   endtask : mem_chk

   task automatic tally_and_finish;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish

   initial begin
      #5_000_000;
      errors++;
      tally_and_finish();
   end

   initial begin
      r = $urandom(32'hf5d75140);
      repeat (20) @(posedge clk_sys_in);
      #1 rst_b_in = 1'b1;
      for (int i = 0; i < 6; i++) begin
         // Fixed words must survive random writes, and an unmapped dword reads zero
         cfg_op(1'b1, (i % 3 == 2) ? 8'h20 : 8'h08 + 8'(i % 3) * 8'h04, 4'hf, $urandom);
         cfg_op(1'b0, 8'h08, 4'h0, 32'h0);
         chk("class word", {8'h06, 8'h00, 8'h00, REV}, rdata);
         cfg_op(1'b0, 8'h0c, 4'h0, 32'h0);
         chk("header word", 32'h0, rdata);
         cfg_op(1'b0, 8'h20, 4'h0, 32'h0);
         chk("unmapped", 32'h0, rdata);
      end
      cfg_op(1'b0, 8'h10, 4'h0, 32'h0);
      chk("aperture reset", 32'h8, rdata);
      chk("enable reset", 32'h0, {31'h0, en_out});
      $display("test fixed_words done");
      for (int i = 0; i < 40; i++) begin
         if (i == 20) begin
            cfg_op(1'b1, 8'h50, 4'b0010, 32'h0000_0200);
            en = 1'b1;
            cfg_op(1'b0, 8'h50, 4'h0, 32'h0);
            chk("misc word", 32'h0000_0200, rdata);
            chk("enable", 32'h1, {31'h0, en_out});
         end
         mask = (i < 2) ? {6{i[0]}} : 6'($urandom);
         r = (i < 2) ? 32'hffff_ffff : $urandom;
         cfg_op(1'b1, 8'h10, (i < 2) ? 4'hf : 4'($urandom), r);
         base = next_base(base, cfg_byte_en_in, r, mask);
         cfg_op(1'b0, 8'h10, 4'h0, 32'h0);
         chk("aperture", {base, 22'h000008}, rdata);
         a = {base, 22'h0} | ($urandom & {4'h0, mask, 22'h3f_ffff});
         mem_chk(a, 1'b1, 1'b1);
         mem_chk(a ^ 32'h8000_0000, 1'b1, 1'b0);
         mem_chk(a, 1'b0, 1'b0);
      end
      $display("test aperture done");
      tally_and_finish();
   end
endmodule : host_bridge_config_header_test
`default_nettype wire
